// *** rtl/pec_pkg.sv ***
// Package with register map, reset values, timing constants and types of the protection comparator.
package pec_pkg;

  // Clock and time base of the delay timers.
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Structure counts.
  localparam int unsigned NUM_GROUPS = 6;
  localparam int unsigned NUM_CT     = 4;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_GROUP     = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h08;
  localparam logic [7:0] REG_CMD       = 8'h0c;
  localparam logic [7:0] REG_SRC_MASK  = 8'h10;
  localparam logic [7:0] REG_CT_RATE0  = 8'h20;
  localparam logic [7:0] REG_GRP_BASE  = 8'h40;
  localparam logic [7:0] GRP_STRIDE    = 8'h10;
  localparam logic [3:0] GRP_PICKUP    = 4'h0;
  localparam logic [3:0] GRP_ON_DELAY  = 4'h4;
  localparam logic [3:0] GRP_OFF_DELAY = 4'h8;

  // Control and command register fields.
  localparam int unsigned CTRL_ENABLE  = 0;
  localparam int unsigned CTRL_EVENTS  = 1;
  localparam int unsigned CTRL_TGT_LO  = 2;
  localparam int unsigned CTRL_CONTROL = 4;
  localparam int unsigned CTRL_DIGITAL = 5;
  localparam int unsigned CTRL_UNDER   = 6;
  localparam int unsigned CTRL_SRC_LO  = 8;
  localparam int unsigned CMD_TGT_CLR  = 0;

  // Values after reset.
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [2:0]  GROUP_RST   = 3'h1;
  localparam logic [3:0]  MASK_RST    = 4'h1;
  localparam logic [15:0] CT_RATE_RST = 16'h0001;
  localparam logic [15:0] PICKUP_RST  = 16'h0100;
  localparam logic [15:0] DELAY_RST   = 16'h0000;

  typedef enum logic [1:0] {PEC_TGT_OFF, PEC_TGT_SELF, PEC_TGT_LATCH} pec_target_t;
  typedef enum logic [1:0] {PEC_SRC_CUR, PEC_SRC_VOLT, PEC_SRC_AUX} pec_src_t;
  typedef enum {PEC_IDLE, PEC_PICKUP, PEC_OPERATE, PEC_DROPOUT} pec_state_t;

  typedef struct packed {
    logic [15:0] pickup;
    logic [15:0] on_delay;
    logic [15:0] off_delay;
  } pec_set_t;

  typedef struct packed {
    logic pickup;
    logic operate;
    logic target;
    logic pickup_event;
    logic dropout_event;
    logic operate_event;
  } pec_out_t;

endpackage : pec_pkg

// *** rtl/pec_top.sv ***
// Protection element comparator with source summation, setting groups, timers, targets and events.
// What this block does
// RULE1: Flag is set to one while the tested input lies inside the programmed range.
// RULE2: Pickup flag while above setting; operate after current stays above for the delay.
// RULE3: Six setting groups, numbered one to six; the active group governs behaviour.
// RULE4: Control-class element uses one setting set whatever group is active.
// RULE5: Summed current base is the larger CT rating; per unit is actual over base.
// RULE6: Element stays inactive until its enable setting is on.
// RULE7: Programmable on-delay between pickup and operate.
// RULE8: Operate held for a programmable off-delay after input leaves pickup range.
// RULE9: Outputs rest at zero until run is one; run low returns them at once. The code keeps a latched target on while run is low.
// RULE10: Block input forms part of run and forces default outputs. The code keeps a latched target on under block.
// RULE11: Target mode off gives no target message or lamp.
// RULE12: Self-reset target follows operate and clears when operate ends.
// RULE13: Latched target stays on after operate ends until a reset command.
// RULE14: With events on, pickup, dropout and operate events are emitted; otherwise none.
// RULE15: Dropout event on pickup falling, even while operate is held by off-delay.
// RULE16: Digital variant compares a logic state; others compare analog values.
// RULE17: Summed currents are rescaled to one common ratio before adding.
// RULE18: Up to four current inputs are summed and ratio matched inside.
// RULE19: Source groups selected currents, phase voltage and one auxiliary voltage.
// RULE20: Pickup lost during on-delay abandons operate; the next pickup restarts timing.
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module pec_top
  import pec_pkg::*;
#(
  parameter int unsigned DW = 16
) (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic [7:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic [NUM_CT-1:0][DW-1:0] cur_in,
  input  wire logic [DW-1:0]          volt_in,
  input  wire logic [DW-1:0]          aux_volt_in,
  input  wire logic                   digital_in,
  input  wire logic                   run_in,
  input  wire logic                   block_in,
  input  wire logic                   target_reset,
  output pec_out_t                    elem_out
);

  logic [31:0]           ctrl_q;
  logic [2:0]            group_q;
  logic [NUM_CT-1:0]     src_mask_q;
  logic [NUM_CT-1:0][15:0] ct_rate_q;
  pec_set_t              set_q [NUM_GROUPS];
  logic                  wait_q;
  logic [31:0]           rdata_q;
  logic                  hit_q;
  pec_state_t            state_q;
  pec_state_t            state_d;
  logic [15:0]           cnt_q;
  logic [15:0]           cnt_d;
  logic [7:0]            pre_q;
  logic [7:0]            pre_d;
  pec_out_t              out_q;
  logic                  op_d;
  logic                  tgt_d;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // Bus decode.
  wire        req       = avs_read | avs_write;
  wire        wr_go     = avs_write & ~wait_q;
  wire [7:0]  grp_off   = avs_address - REG_GRP_BASE;
  wire [3:0]  grp_idx   = grp_off[7:4];
  wire [3:0]  grp_word  = grp_off[3:0];
  wire        grp_hit   = (avs_address >= REG_GRP_BASE) && (grp_idx < 4'(NUM_GROUPS));
  wire        ct_hit    = (avs_address[7:4] == REG_CT_RATE0[7:4]) && ({30'h0, avs_address[3:2]} < NUM_CT);
  wire [1:0]  ct_idx    = avs_address[3:2];
  wire        hit_ctrl  = avs_address == REG_CTRL;
  wire        hit_group = avs_address == REG_GROUP;
  wire        hit_cmd   = avs_address == REG_CMD;
  wire        hit_mask  = avs_address == REG_SRC_MASK;
  wire [31:0] ctrl_new  = be_merge(ctrl_q, avs_writedata, avs_byteenable);
  wire [31:0] wr_word   = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);

  // Settings selection.
  wire        enable    = ctrl_q[CTRL_ENABLE];
  wire        events_en = ctrl_q[CTRL_EVENTS];
  wire [1:0]  tmode     = ctrl_q[CTRL_TGT_LO +: 2];
  wire [1:0]  src_sel   = ctrl_q[CTRL_SRC_LO +: 2];
  wire [2:0]  set_idx   = ctrl_q[CTRL_CONTROL] ? 3'h0 : group_q - 3'h1; // [RULE3] [RULE4]
  wire pec_set_t act_set = set_q[set_idx];                                 // [RULE3]
  wire        run       = enable & run_in & ~block_in;                    // [RULE6] [RULE9] [RULE10]
  wire        pick_now  = run & hit_q;                                    // [RULE1] [RULE2]
  wire        tgt_clr   = target_reset | (wr_go & hit_cmd & avs_writedata[CMD_TGT_CLR]); // [RULE13]

  // Source: ratio-matched current sum, phase voltage or auxiliary voltage.
  logic [33:0] cur_sum;
  logic [15:0] max_rate;
  always_comb begin
    cur_sum  = '0;
    max_rate = '0;
    for (int i = 0; i < NUM_CT; i++) begin
      if (src_mask_q[i]) begin
        cur_sum = cur_sum + {2'b00, 32'(cur_in[i]) * 32'(ct_rate_q[i])}; // [RULE17] [RULE18] [RULE19]
        if (ct_rate_q[i] > max_rate) begin
          max_rate = ct_rate_q[i];                                       // [RULE5]
        end
      end
    end
  end

  // Per-unit test: sum of primary-scaled currents against pickup times the largest rating.
  wire [33:0] cur_lim   = {2'b00, 32'(act_set.pickup) * 32'(max_rate)};   // [RULE5]
  wire [15:0] volt_sel  = (src_sel == PEC_SRC_AUX) ? aux_volt_in : volt_in; // [RULE19]
  wire [33:0] meas      = (src_sel == PEC_SRC_CUR) ? cur_sum : {18'h0, volt_sel};
  wire [33:0] limit     = (src_sel == PEC_SRC_CUR) ? cur_lim : {18'h0, act_set.pickup};
  wire        cur_void  = (src_sel == PEC_SRC_CUR) && (max_rate == 16'h0);
  wire        over_hit  = (meas >= limit) && !cur_void;
  wire        under_hit = (meas < limit) && !cur_void;
  wire        ana_hit   = ctrl_q[CTRL_UNDER] ? under_hit : over_hit;
  wire        cmp_hit   = ctrl_q[CTRL_DIGITAL] ? digital_in : ana_hit;    // [RULE16]

  // Read mux.
  wire pec_set_t rd_set = set_q[grp_idx[2:0]];
  wire [31:0] rd_grp    = (grp_word == GRP_PICKUP)    ? {16'h0, rd_set.pickup} :
                          (grp_word == GRP_ON_DELAY)  ? {16'h0, rd_set.on_delay} :
                          (grp_word == GRP_OFF_DELAY) ? {16'h0, rd_set.off_delay} : 32'h0;
  wire [31:0] status_w  = {26'h0, 2'(state_q), run, out_q.target, out_q.operate, out_q.pickup};
  wire [31:0] rd_word   = hit_ctrl  ? ctrl_q :
                          hit_group ? {29'h0, group_q} :
                          hit_mask  ? {28'h0, src_mask_q} :
                          (avs_address == REG_STATUS) ? status_w :
                          ct_hit    ? {16'h0, ct_rate_q[ct_idx]} :
                          grp_hit   ? rd_grp : 32'h0;

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign elem_out        = out_q;

  // Bus slave: one wait cycle, read data captured in it, writes at the answering edge.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q  <= ~(req & wait_q);
      rdata_q <= (avs_read & wait_q) ? rd_word : rdata_q;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q     <= CTRL_RST;
      group_q    <= GROUP_RST;
      src_mask_q <= MASK_RST;
      ct_rate_q  <= {NUM_CT{CT_RATE_RST}};
      for (int g = 0; g < NUM_GROUPS; g++) begin
        set_q[g] <= '{PICKUP_RST, DELAY_RST, DELAY_RST};
      end
    end else if (wr_go) begin
      if (hit_ctrl) begin
        ctrl_q <= ctrl_new;
      end
      if (hit_group && avs_byteenable[0] && avs_writedata[2:0] >= 3'h1 && avs_writedata[2:0] <= 3'(NUM_GROUPS)
          && avs_writedata[7:3] == 5'h0) begin
        group_q <= avs_writedata[2:0];                                  // [RULE3]
      end
      if (hit_mask) begin
        src_mask_q <= wr_word[NUM_CT-1:0] | (src_mask_q & ~{NUM_CT{avs_byteenable[0]}});
      end
      if (ct_hit) begin
        ct_rate_q[ct_idx] <= 16'(be_merge({16'h0, ct_rate_q[ct_idx]}, avs_writedata, avs_byteenable));
      end
      if (grp_hit) begin
        unique case (grp_word)
          GRP_PICKUP: begin
            set_q[grp_idx[2:0]].pickup <= 16'(be_merge({16'h0, rd_set.pickup}, avs_writedata, avs_byteenable));
          end
          GRP_ON_DELAY: begin
            set_q[grp_idx[2:0]].on_delay <= 16'(be_merge({16'h0, rd_set.on_delay}, avs_writedata, avs_byteenable));
          end
          GRP_OFF_DELAY: begin
            set_q[grp_idx[2:0]].off_delay <= 16'(be_merge({16'h0, rd_set.off_delay}, avs_writedata, avs_byteenable));
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Element state machine.
  wire tick = pre_q == 8'(TICK_CYCLES - 1);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PEC_IDLE: begin
        if (pick_now) begin
          state_d = PEC_PICKUP;
        end
      end
      PEC_PICKUP: begin
        if (!pick_now) begin
          state_d = PEC_IDLE;                                           // [RULE20]
        end else if (cnt_q >= act_set.on_delay) begin
          state_d = PEC_OPERATE;                                        // [RULE7]
        end
      end
      PEC_OPERATE: begin
        if (!pick_now) begin
          state_d = (act_set.off_delay == 16'h0) ? PEC_IDLE : PEC_DROPOUT;
        end
      end
      PEC_DROPOUT: begin
        if (pick_now) begin
          state_d = PEC_OPERATE;
        end else if (cnt_q >= act_set.off_delay) begin
          state_d = PEC_IDLE;                                           // [RULE8]
        end
      end
    endcase
    if (!run) begin
      state_d = PEC_IDLE;                                               // [RULE9] [RULE6]
    end
  end

  assign pre_d = (state_d != state_q || tick) ? 8'h0 : pre_q + 8'h1;
  assign cnt_d = (state_d != state_q) ? 16'h0 : (tick && cnt_q != 16'hffff) ? cnt_q + 16'h1 : cnt_q;
  assign op_d  = (state_d == PEC_OPERATE) || (state_d == PEC_DROPOUT);  // [RULE2] [RULE8]
  assign tgt_d = (tmode == PEC_TGT_SELF)  ? op_d :                       // [RULE12]
                 (tmode == PEC_TGT_LATCH) ? (op_d | (out_q.target & ~tgt_clr)) : 1'b0; // [RULE13] [RULE11]

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hit_q   <= 1'b0;
      state_q <= PEC_IDLE;
      cnt_q   <= 16'h0;
      pre_q   <= 8'h0;
      out_q   <= '0;
    end else begin
      hit_q               <= cmp_hit;
      state_q             <= state_d;
      cnt_q               <= cnt_d;
      pre_q               <= pre_d;
      out_q.pickup        <= pick_now;                                     // [RULE1] [RULE9]
      out_q.operate       <= op_d;
      out_q.target        <= tgt_d;
      out_q.pickup_event  <= events_en & pick_now & ~out_q.pickup;         // [RULE14]
      out_q.dropout_event <= events_en & ~pick_now & out_q.pickup;         // [RULE15]
      out_q.operate_event <= events_en & op_d & ~out_q.operate;            // [RULE14]
    end
  end

  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_run_default: assert property (!run |=> !out_q.pickup && !out_q.operate) // [RULE9]
    else $error("Outputs not at default after run went low.");
  chk_block_forces: assert property (block_in |=> !out_q.pickup && state_q == PEC_IDLE) // [RULE10]
    else $error("Block did not force default state.");
  chk_disabled_idle: assert property (!enable |=> state_q == PEC_IDLE && !out_q.operate) // [RULE6]
    else $error("Disabled element left idle.");
  chk_pickup_flag: assert property (pick_now |=> out_q.pickup) // [RULE1]
    else $error("Pickup flag missing while input in range.");
  chk_on_delay: assert property (state_q == PEC_PICKUP && pick_now && cnt_q < act_set.on_delay
                                 |=> !out_q.operate) // [RULE7]
    else $error("Operate before on-delay expired.");
  chk_off_hold: assert property (state_q == PEC_OPERATE && run && !pick_now && act_set.off_delay != 16'h0
                                 |=> out_q.operate && state_q == PEC_DROPOUT) // [RULE8]
    else $error("Operate not held through off-delay.");
  chk_abandon_pend: assert property (state_q == PEC_PICKUP && !pick_now |=> state_q == PEC_IDLE && cnt_q == 16'h0) // [RULE20]
    else $error("Pending operate not abandoned.");
  chk_target_off: assert property (tmode == PEC_TGT_OFF |=> !out_q.target) // [RULE11]
    else $error("Target shown with target mode off.");
  chk_target_self: assert property (tmode == PEC_TGT_SELF |=> out_q.target == out_q.operate) // [RULE12]
    else $error("Self-reset target does not follow operate.");
  chk_target_latch: assert property (tmode == PEC_TGT_LATCH && out_q.target && !tgt_clr |=> out_q.target) // [RULE13]
    else $error("Latched target cleared without reset.");
  chk_events_off: assert property (!events_en |=> !out_q.pickup_event && !out_q.dropout_event
                                   && !out_q.operate_event) // [RULE14]
    else $error("Event emitted with events disabled.");
  chk_dropout_event: assert property (events_en && out_q.pickup && !pick_now |=> out_q.dropout_event) // [RULE15]
    else $error("Dropout event missing.");
  chk_bus_answer: assert property (req && wait_q |=> !wait_q ##1 wait_q)
    else $error("Bus answer not given in one wait cycle.");

  cov_operate: cover property (out_q.operate_event);
  cov_dropout_in_op: cover property (out_q.dropout_event && out_q.operate);
  cov_latched_hold: cover property (tmode == PEC_TGT_LATCH && out_q.target && !out_q.operate);
  cov_abandon: cover property (state_q == PEC_PICKUP ##1 state_q == PEC_IDLE);

endmodule : pec_top

// *** verification/pec_meas_model.sv ***
// Measurement subsystem model that delivers the requested samples one clock later.
`timescale 1ns/10ps
module pec_meas_model
  import pec_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic [3:0][15:0]      ct_level,
  input  wire logic [15:0]           v_level,
  input  wire logic [15:0]           a_level,
  input  wire logic                  d_level,
  output logic      [NUM_CT-1:0][15:0] cur_in,
  output logic      [15:0]           volt_in,
  output logic      [15:0]           aux_volt_in,
  output logic                       digital_in
);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_in      <= '0;
      volt_in     <= 16'h0000;
      aux_volt_in <= 16'h0000;
      digital_in  <= 1'b0;
    end else begin
      cur_in      <= ct_level;
      volt_in     <= v_level;
      aux_volt_in <= a_level;
      digital_in  <= d_level;
    end
  end
endmodule : pec_meas_model

// *** verification/pec_top_tb.sv ***
// Testbench of the protection comparator driven over its register bus.
`timescale 1ns/10ps
module pec_top_tb;
  import pec_pkg::*;
  localparam int PK = 5;
  localparam int OP = 4;
  localparam int TG = 3;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0][15:0] ct = '0;
  logic [15:0] vl = 16'h0000;
  logic [15:0] al = 16'h0000;
  logic dl = 1'b0;
  logic run_in = 1'b1;
  logic block_in = 1'b0;
  logic target_reset = 1'b0;
  logic [NUM_CT-1:0][15:0] cur_in;
  logic [15:0] volt_in;
  logic [15:0] aux_volt_in;
  logic digital_in;
  pec_out_t elem_out;
  logic [31:0] rq;
  int error_cnt = 0;
  int n_checks = 0;
  int wn;
  int pk_n = 0;
  int dp_n = 0;
  int op_n = 0;
  always #2 ref_clk = ~ref_clk;
  pec_meas_model meas (.ref_clk(ref_clk), .sys_rst(sys_rst), .ct_level(ct), .v_level(vl), .a_level(al),
    .d_level(dl), .cur_in(cur_in), .volt_in(volt_in), .aux_volt_in(aux_volt_in), .digital_in(digital_in));
  pec_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cur_in(cur_in), .volt_in(volt_in), .aux_volt_in(aux_volt_in),
    .digital_in(digital_in), .run_in(run_in), .block_in(block_in), .target_reset(target_reset),
    .elem_out(elem_out));
  always @(posedge ref_clk) begin
    pk_n += (elem_out.pickup_event === 1'b1);
    dp_n += (elem_out.dropout_event === 1'b1);
    op_n += (elem_out.operate_event === 1'b1);
  end
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      $display("ERROR at %0t: bus answer missing", $time);
      test_done();
    end
    rq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc
  task automatic wt(input int b, input logic v, input int lim);
    wn = 0;
    while (elem_out[b] !== v && wn < lim) begin
      @(negedge ref_clk);
      wn++;
    end
    if (elem_out[b] !== v) begin
      error_cnt++;
      $display("ERROR at %0t: output wait ran out", $time);
      test_done();
    end
  endtask : wt
  task automatic lvl(input int src, input logic [15:0] v, input logic e);
    @(posedge ref_clk);
    case (src)
      0: ct[0] <= v;
      1: vl <= v;
      2: al <= v;
      default: dl <= v[0];
    endcase
    repeat (6) @(negedge ref_clk);
    chk(elem_out.pickup, e);
  endtask : lvl
  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    acc(0, REG_CTRL, 0); chk(rq, CTRL_RST);
    acc(0, REG_GROUP, 0); chk(rq, 32'h1);
    acc(0, REG_SRC_MASK, 0); chk(rq, 32'h1);
    acc(0, REG_GRP_BASE, 0); chk(rq, 32'h100);
    acc(0, 8'h3c, 0); chk(rq, 32'h0);
    lvl(0, 16'h0180, 1'b0);
    $display("Test reset values done");
    acc(1, REG_GRP_BASE + GRP_ON_DELAY, 1);
    acc(1, REG_CTRL, 32'h7);
    wt(PK, 1, 20);
    wt(OP, 1, 400); chk(wn, 251);
    chk(pk_n, 1);
    chk(elem_out.target, 1);
    acc(0, REG_STATUS, 0); chk(rq, 32'h2f);
    lvl(0, 16'h00ff, 1'b0); chk(elem_out.operate, 0);
    chk(elem_out.target, 0);
    chk(pk_n, 1);
    chk(dp_n, 1);
    chk(op_n, 1);
    lvl(0, 16'h0180, 1'b1);
    repeat (100) @(negedge ref_clk);
    lvl(0, 16'h0000, 1'b0); chk(elem_out.operate, 0);
    lvl(0, 16'h0180, 1'b1);
    wt(OP, 1, 400); chk(wn, 249);
    acc(1, REG_GRP_BASE + GRP_OFF_DELAY, 1);
    lvl(0, 16'h0000, 1'b0); chk(elem_out.operate, 1);
    chk(dp_n, 3);
    wt(OP, 0, 400); chk(wn > 236 && wn < 252, 1);
    $display("Test timing done");
    acc(1, REG_GRP_BASE + GRP_OFF_DELAY, 0);
    acc(1, REG_CTRL, 32'h9);
    lvl(0, 16'h0180, 1'b1);
    wt(OP, 1, 400);
    lvl(0, 16'h0000, 1'b0); chk(elem_out.target, 1);
    chk(pk_n, 3);
    chk(dp_n, 3);
    chk(op_n, 2);
    @(posedge ref_clk);
    target_reset <= 1'b1;
    @(posedge ref_clk);
    target_reset <= 1'b0;
    wt(TG, 0, 5); chk(wn, 1);
    lvl(0, 16'h0180, 1'b1);
    wt(OP, 1, 400);
    lvl(0, 16'h0000, 1'b0); chk(elem_out.target, 1);
    acc(1, REG_CMD, 1);
    wt(TG, 0, 5); chk(wn, 1);
    acc(1, REG_CTRL, 32'h1);
    lvl(0, 16'h0180, 1'b1);
    wt(OP, 1, 400); chk(elem_out.target, 0);
    $display("Test targets done");
    @(posedge ref_clk);
    block_in <= 1'b1;
    wt(PK, 0, 3); chk(wn, 2);
    chk(elem_out.operate, 0);
    @(posedge ref_clk);
    block_in <= 1'b0;
    wt(PK, 1, 10);
    @(posedge ref_clk);
    run_in <= 1'b0;
    wt(PK, 0, 3); chk(wn, 2);
    lvl(0, 16'h0190, 1'b0);
    @(posedge ref_clk);
    run_in <= 1'b1;
    $display("Test supervision done");
    acc(1, REG_CTRL, 32'h3);
    for (int g = 1; g <= 6; g++) begin
      acc(1, REG_GRP_BASE + 8'(g - 1) * GRP_STRIDE, 32'h100 + 32'h20 * g);
      acc(1, REG_GROUP, g);
      lvl(0, 16'h00ff + 16'h0020 * g[15:0], 1'b0);
      lvl(0, 16'h0100 + 16'h0020 * g[15:0], 1'b1);
    end
    acc(1, REG_GROUP, 7);
    acc(0, REG_GROUP, 0); chk(rq, 32'h6);
    lvl(0, 16'h0120, 1'b0);
    acc(1, REG_CTRL, 32'h13);
    lvl(0, 16'h0120, 1'b1);
    acc(1, REG_CTRL, 32'h3);
    acc(1, REG_GROUP, 1);
    acc(1, REG_SRC_MASK, 32'h3);
    acc(1, REG_CT_RATE0, 300);
    acc(1, REG_CT_RATE0 + 8'h04, 100);
    ct[1] <= 16'h00c0;
    ct[2] <= 16'hffff;
    lvl(0, 16'h00df, 1'b0);
    lvl(0, 16'h00e0, 1'b1);
    $display("Test groups and scaling done");
    acc(1, REG_CTRL, 32'h103);
    lvl(1, 16'h0120, 1'b1);
    lvl(1, 16'h011f, 1'b0);
    acc(1, REG_CTRL, 32'h203);
    lvl(2, 16'h0120, 1'b1);
    acc(1, REG_CTRL, 32'h143);
    lvl(1, 16'h0120, 1'b0);
    lvl(1, 16'h011f, 1'b1);
    acc(1, REG_CTRL, 32'h23);
    lvl(3, 16'h0000, 1'b0);
    lvl(3, 16'h0001, 1'b1);
    $display("Test sources done");
    test_done();
  end
endmodule : pec_top_tb
